/* File: inc/pot_pkg.sv */
// shared constants, command codes and carrier types of the quad pot command unit
package pot_pkg;

  // clock rate of ref_clk
  localparam int CLK_FREQ_MHZ      = 125;

  // frame geometry
  localparam int FRAME_BITS        = 16;
  localparam int WIPER_COUNT       = 4;
  localparam int WIPER_BITS        = 6;
  localparam int NV_WORDS          = 16;

  // wiper codes
  localparam logic [5:0] WIPER_MIDSCALE = 6'h20;
  localparam logic [5:0] WIPER_TOP      = 6'h3F;
  localparam logic [5:0] WIPER_ZERO     = 6'h00;

  // value after reset of the nonvolatile words past the wipers
  localparam logic [7:0] NV_USER_RESET  = 8'hFF;

  // nonvolatile store time, in milliseconds, and its cycle count
  localparam int STORE_TIME_MS     = 25;
  localparam int STORE_CYCLES      = STORE_TIME_MS * 1000 * CLK_FREQ_MHZ;

  // width of the low pulse on the ready pin, in nanoseconds, and its cycle count
  localparam int READY_PULSE_NS    = 1000;
  localparam int READY_PULSE_CYCLES = (READY_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;

  // width of the cycle counter used for the store and ready timing
  localparam int TIMER_BITS        = 22;

  // command codes
  localparam logic [3:0] CMD_NOP          = 4'h0;
  localparam logic [3:0] CMD_RESTORE_ONE  = 4'h1;
  localparam logic [3:0] CMD_STORE_WIPER  = 4'h2;
  localparam logic [3:0] CMD_STORE_DATA   = 4'h3;
  localparam logic [3:0] CMD_HALVE_ONE    = 4'h4;
  localparam logic [3:0] CMD_HALVE_ALL    = 4'h5;
  localparam logic [3:0] CMD_DEC_ONE      = 4'h6;
  localparam logic [3:0] CMD_DEC_ALL      = 4'h7;
  localparam logic [3:0] CMD_RESTORE_ALL  = 4'h8;
  localparam logic [3:0] CMD_READ_NV      = 4'h9;
  localparam logic [3:0] CMD_READ_WIPER   = 4'hA;
  localparam logic [3:0] CMD_WRITE_WIPER  = 4'hB;
  localparam logic [3:0] CMD_DOUBLE_ONE   = 4'hC;
  localparam logic [3:0] CMD_DOUBLE_ALL   = 4'hD;
  localparam logic [3:0] CMD_INC_ONE      = 4'hE;
  localparam logic [3:0] CMD_INC_ALL      = 4'hF;

  // one command frame, most significant field first
  typedef struct packed {
    logic [3:0] command_bits;
    logic [3:0] address_bits;
    logic [7:0] data_bits;
  } frame_s;

  // the four wiper positions as seen by the analog side
  typedef struct packed {
    logic [WIPER_COUNT-1:0][WIPER_BITS-1:0] wiper_scratchpad;
  } wiper_bus_s;

  // phases of the unit
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_STORE,
    PH_READY
  } phase_e;

  // whole state of the unit
  typedef struct packed {
    logic                                   sclk_s1;
    logic                                   sclk_s2;
    logic                                   sclk_s3;
    logic                                   cs_s1;
    logic                                   cs_s2;
    logic                                   cs_s3;
    logic                                   sdi_s1;
    logic                                   sdi_s2;
    logic                                   wp_s1;
    logic                                   wp_s2;
    logic                                   pr_s1;
    logic                                   pr_s2;
    logic                                   pr_s3;
    logic [FRAME_BITS-1:0]                  shift;
    logic [3:0]                             bit_cnt;
    logic                                   any_bits;
    frame_s                                 last_frame;
    logic                                   last_valid;
    phase_e                                 phase;
    logic [TIMER_BITS-1:0]                  timer;
    logic [3:0]                             store_addr;
    logic [7:0]                             store_data;
    logic [WIPER_COUNT-1:0][WIPER_BITS-1:0] wiper;
    logic [NV_WORDS-1:0][7:0]               nv;
    logic                                   sdo_oe;
    logic                                   rdy_oe;
  } unit_state_s;

endpackage : pot_pkg

/* File: tb/pot_host.sv */
// serial host model that shifts command frames into the unit
`timescale 1ns/1ns

module pot_host
(
  output logic      sclk,     // serial clock, still outside frames
  output logic      cs_n,     // chip select, active low
  output logic      sdi,      // serial data to the unit
  input  wire logic sdo_pin   // resolved open-drain serial out
);
  // idle levels at time zero
  initial
  begin
    sclk = 1'h0;
    cs_n = 1'h1;
    sdi  = 1'h0;
  end

  // shift nbits of word msb first in mode 0 or 3, collect returned bits
  task automatic xfer(input logic [31:0] word, input int nbits, input logic cpol,
                      output logic [31:0] rx);
    rx   = 32'h00000000;
    sclk = cpol;
    #80;          // clock settles at its idle level before select falls: no false edge
    cs_n = 1'h0;
    #80;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sclk = 1'h0;
      sdi  = word[i];
      #62;
      sclk = 1'h1;
      rx   = {rx[30:0], sdo_pin};
      #63;
    end
    sclk = cpol;
    #20;
    cs_n = 1'h1;
    sdi  = ~sdi;  // released line shows no stale level
    #100;
  endtask : xfer

  // select pulse with no clock edges
  task automatic pulse_cs();
    cs_n = 1'h0;
    #80;
    cs_n = 1'h1;
    #100;
  endtask : pulse_cs
endmodule : pot_host

/* File: tb/pot_monitor.sv */
// port-level assertions for the quad pot serial command unit
`timescale 1ns/1ns

module pot_monitor
  import pot_pkg::*;
#(
  parameter int STORE_WAIT = STORE_CYCLES  // cycles of one nonvolatile store
)
(
  input wire logic       ref_clk,          // system clock
  input wire logic       arst_n,           // asynchronous reset, active low
  input wire logic       sclk,             // serial clock
  input wire logic       cs_n,             // chip select, active low
  input wire logic       sdi,              // serial data in
  input wire logic       wp_n,             // write protect, active low
  input wire logic       preset_strobe_n,  // preset strobe, active low
  input wire logic       sdo_o,            // serial out level when driven
  input wire logic       sdo_oe,           // serial out pulled low
  input wire logic       rdy_o,            // ready level when driven
  input wire logic       rdy_oe,           // ready pulled low
  input wire logic       store_busy,       // store in progress
  input wire wiper_bus_s wipers            // wiper positions
);
  logic        cs_d;       // select one cycle ago
  logic        pr_d;       // preset one cycle ago
  logic [7:0]  quiet_cnt;  // cycles since select rose or preset moved
  logic [7:0]  rdy_cnt;    // length of the running ready pulse
  logic [23:0] busy_cnt;   // length of the running store

  // edge history and pulse length counters
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_d      <= 1'h1;
      pr_d      <= 1'h1;
      quiet_cnt <= 8'h00;
      rdy_cnt   <= 8'h00;
      busy_cnt  <= 24'h000000;
    end
    else
    begin
      cs_d      <= cs_n;
      pr_d      <= preset_strobe_n;
      quiet_cnt <= ((cs_n && !cs_d) || (preset_strobe_n != pr_d)) ? 8'h00
                   : quiet_cnt + {7'h00, quiet_cnt != 8'hFF};
      rdy_cnt   <= rdy_oe ? rdy_cnt + 8'h01 : 8'h00;
      busy_cnt  <= store_busy ? busy_cnt + 24'h000001 : 24'h000000;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_sdo_release; cs_n [*6] |-> !sdo_oe; endproperty
  property p_sdo_level; sdo_oe |-> !sdo_o; endproperty
  property p_rdy_level; rdy_oe |-> !rdy_o; endproperty
  property p_rdy_after_store; $fell(store_busy) |-> ##[0:2] rdy_oe; endproperty
  property p_rdy_width; $fell(rdy_oe) |-> rdy_cnt == READY_PULSE_CYCLES; endproperty
  property p_store_len;
    $fell(store_busy) |-> busy_cnt >= STORE_WAIT - 1 && busy_cnt <= STORE_WAIT + 1;
  endproperty
  property p_store_lock; preset_strobe_n [*6] ##0 store_busy [*2] |-> $stable(wipers); endproperty
  property p_reset_mid;
    $rose(arst_n) |-> wipers.wiper_scratchpad == {WIPER_COUNT{WIPER_MIDSCALE}};
  endproperty
  property p_preset_mid;
    !preset_strobe_n [*6] |-> wipers.wiper_scratchpad == {WIPER_COUNT{WIPER_MIDSCALE}};
  endproperty
  property p_decode_on_cs; $changed(wipers) |-> quiet_cnt <= 8'h08; endproperty

  a_sdo_release: assert property (p_sdo_release)
    else $error("serial out driven while deselected");
  a_sdo_level: assert property (p_sdo_level)
    else $error("serial out driven high");
  a_rdy_level: assert property (p_rdy_level)
    else $error("ready driven high");
  a_rdy_after_store: assert property (p_rdy_after_store)
    else $error("no ready pulse after store");
  a_rdy_width: assert property (p_rdy_width)
    else $error("ready pulse width wrong");
  a_store_len: assert property (p_store_len)
    else $error("store length wrong");
  a_store_lock: assert property (p_store_lock)
    else $error("wiper moved during store");
  a_reset_mid: assert property (p_reset_mid)
    else $error("wipers not midscale after reset");
  a_preset_mid: assert property (p_preset_mid)
    else $error("preset low without midscale");
  a_decode_on_cs: assert property (p_decode_on_cs)
    else $error("wiper moved without select rise");

  c_store: cover property ($fell(store_busy));
  c_ready: cover property ($fell(rdy_oe));
  c_preset: cover property ($rose(preset_strobe_n));
endmodule : pot_monitor

bind quad_pot_serial_command_unit pot_monitor #(.STORE_WAIT(STORE_WAIT)) pot_monitor_i (
  .ref_clk, .arst_n, .sclk, .cs_n, .sdi, .wp_n, .preset_strobe_n,
  .sdo_o, .sdo_oe, .rdy_o, .rdy_oe, .store_busy, .wipers);

/* File: tb/testbench.sv */
// self-checking bench for the quad pot serial command unit
`timescale 1ns/1ns

module testbench
  import pot_pkg::*;
;
  localparam int STORE_SIM = 400;  // shortened store length
  logic        ref_clk, arst_n, wp_n, preset_strobe_n;
  logic        sclk, cs_n, sdi, sdo_o, sdo_oe, rdy_o, rdy_oe, store_busy;
  wire logic   sdo_pin;
  wiper_bus_s  wipers;
  logic [31:0] rx;
  int          mismatches, comparisons;

  // pull-up on the open-drain serial out
  assign sdo_pin = (sdo_oe === 1'h1) ? 1'h0 : 1'h1;

  quad_pot_serial_command_unit #(.STORE_WAIT(STORE_SIM)) quad_pot_serial_command_unit_i (
    .ref_clk, .arst_n, .sclk, .cs_n, .sdi, .wp_n, .preset_strobe_n,
    .sdo_o, .sdo_oe, .rdy_o, .rdy_oe, .store_busy, .wipers);
  pot_host pot_host_i (.sclk, .cs_n, .sdi, .sdo_pin);

  // free-running clock
  initial
  begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic send(input logic [15:0] w);
    pot_host_i.xfer({16'h0000, w}, 16, 1'h0, rx);
  endtask : send

  function automatic logic [5:0] wpr(input int i);
    return wipers.wiper_scratchpad[i];
  endfunction : wpr

  // expected wiper after a step command
  function automatic logic [5:0] step(input logic [3:0] c, input logic [5:0] v);
    case (c[3:1])
      3'h2: return v >> 1;
      3'h3: return (v == 6'h00) ? v : v - 6'h01;
      3'h6: return (v >= 6'h20) ? 6'h3F : v << 1;
      default: return (v == 6'h3F) ? v : v + 6'h01;
    endcase
  endfunction : step

  // wait for the end of the ready pulse
  task automatic wait_store();
    int n;
    n = 0;
    while (rdy_oe !== 1'h1 && n < 1000)
    begin
      tick(1);
      n++;
    end
    check(rdy_oe, 1'h1, "ready pulse seen");
    check(store_busy, 1'h0, "busy during ready");
    while (rdy_oe === 1'h1 && n < 1500)
    begin
      tick(1);
      n++;
    end
    check(n < 1500, 1'h1, "ready pulse");
  endtask : wait_store

  // reset, then a bare select pulse must not repeat anything
  task automatic t_reset();
    tick(1);
    arst_n = 1'h0;
    tick(4);
    arst_n = 1'h1;
    tick(4);
    pot_host_i.pulse_cs();
    for (int i = 0; i < 4; i++)
      check(wpr(i), 6'h20, "power-on midscale");
  endtask : t_reset

  task automatic t_basic();
    send(16'hB010);
    check(wpr(0), 6'h10, "write wiper");
    send(16'hB1FF);
    check(wpr(1), 6'h3F, "upper data bits");
    send(16'hB300);
    check(wpr(3), 6'h00, "zero code");
    send(16'h0000);
    check(rx[15:0], 16'hB300, "previous word");
    pot_host_i.xfer(32'h0000B22A, 16, 1'h1, rx);
    check(wpr(2), 6'h2A, "mode 3 frame");
    pot_host_i.xfer(32'hB005B13C, 32, 1'h0, rx);
    check({wpr(0), wpr(1)}, 12'h43C, "long frame");
    check(rx, 32'hB22AB005, "daisy out");
    pot_host_i.xfer(32'h0000B03F, 15, 1'h0, rx);
    pot_host_i.xfer(32'h00000B03, 12, 1'h0, rx);
    check(wpr(0), 6'h10, "short frames dropped");
    send(16'hB011);
    check(wpr(0), 6'h11, "count cleared");
  endtask : t_basic

  task automatic t_steps();
    logic [3:0] codes [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF};
    logic [5:0] v [4] = '{6'h00, 6'h01, 6'h21, 6'h3F};
    logic [1:0] a;
    foreach (codes[k])
    begin
      for (int i = 0; i < 4; i++)
        send({4'hB, 4'(i), 2'h0, v[i]});
      a = codes[k][3] ? 2'h3 : 2'h0;
      send({codes[k], 2'h0, a, 8'h00});
      for (int i = 0; i < 4; i++)
        check(wpr(i), (codes[k][0] || a == i) ? step(codes[k], v[i]) : v[i],
              "step");
    end
    pot_host_i.pulse_cs();
    for (int i = 0; i < 4; i++)
      check(wpr(i), step(4'hF, step(4'hF, v[i])), "repeat");
  endtask : t_steps

  task automatic t_store();
    send(16'hB111);
    send(16'h2100);
    check(store_busy, 1'h1, "store started");
    send(16'hB12A);
    check(wpr(1), 6'h11, "locked");
    wait_store();
    send(16'hB107);
    send(16'h1100);
    check(wpr(1), 6'h11, "restore one");
    send(16'hA100);
    send(16'h0000);
    check(rx[15:0], 16'hA111, "read wiper");
    send(16'h3155);
    wait_store();
    send(16'h9100);
    send(16'h0000);
    check(rx[15:0], 16'h9155, "read store");
    send(16'h8000);
    check({wpr(0), wpr(1)}, 12'h815, "restore all");
  endtask : t_store

  task automatic t_preset();
    send(16'hB13F);
    preset_strobe_n = 1'h0;
    tick(10);
    check(wpr(1), 6'h20, "preset low");
    preset_strobe_n = 1'h1;
    tick(10);
    check(wpr(1), 6'h15, "preset reload");
  endtask : t_preset

  task automatic t_wp();
    send(16'hB23F);
    wp_n = 1'h0;
    tick(4);
    send(16'hB201);
    send(16'hE200);
    check(wpr(2), 6'h3F, "protected");
    send(16'h2200);
    check(store_busy, 1'h0, "store blocked");
    send(16'h8000);
    check(wpr(2), 6'h20, "restore under protect");
    send(16'h0000);
    wp_n = 1'h1;
    tick(4);
    send(16'hB20A);
    check(wpr(2), 6'h0A, "unprotected");
  endtask : t_wp

  // main sequence
  initial
  begin
    arst_n          = 1'h0;
    wp_n            = 1'h1;
    preset_strobe_n = 1'h1;
    mismatches      = 0;
    comparisons     = 0;
    t_reset();
    t_basic();
    t_steps();
    t_store();
    t_preset();
    t_wp();
    t_reset();
    complete_run();
  end

  // hang guard
  initial
  begin
    #500000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule : testbench

/* File: verilog/quad_pot_serial_command_unit.sv */
// serial command interpreter, wiper scratchpads and nonvolatile store of the quad pot
//
// What this block does
// - sixteen-bit frames shift in msb first, select low
// - decode and execute only on select rising
// - wiper loads keep only six low data bits
// - bit counter frames in sixteens, thirty-two accepted
// - bare select pulse repeats last command, not at power-up
// - count not multiple of four: discard and clear
// - serial output released while select is high
// - slave modes: cpol0/cpha0 and cpol1/cpha1
// - store lasts 25 ms, shifter locked meanwhile
// - ready pin pulses low when store completes
// - codes 0..7: nop restore store halve decrement
// - codes 8..15: reload read write double increment
// - zero code means wiper at b terminal
// - power-on loads wipers from stored values, midscale
// - command 1 or 8 reloads wipers from store
// - preset low sets midscale, rising edge reloads
// - write protect low blocks all but restores and reads
// - command 11 writes wiper, command 2 stores it
// - serial output returns previous frame's word
// - frame: command, address, data fields msb first
// - halving shifts right, stops at zero
// - factory stored code is midscale 0x20
`timescale 1ns/1ns

module quad_pot_serial_command_unit
  import pot_pkg::*;
#(
  parameter int STORE_WAIT = STORE_CYCLES   // cycles of one nonvolatile store
)
(
  input  wire logic       ref_clk,          // 125 MHz system clock
  input  wire logic       arst_n,           // asynchronous reset, active low
  input  wire logic       sclk,             // serial clock from the host
  input  wire logic       cs_n,             // chip select, active low
  input  wire logic       sdi,              // serial data in
  input  wire logic       wp_n,             // write protect, active low
  input  wire logic       preset_strobe_n,  // preset strobe, active low
  output logic            sdo_o,            // open-drain serial data out, level when driven
  output logic            sdo_oe,           // serial data out pulled low while high
  output logic            rdy_o,            // open-drain ready, level when driven
  output logic            rdy_oe,           // ready pulled low while high
  output logic            store_busy,       // nonvolatile store in progress
  output wiper_bus_s      wipers            // wiper positions to the resistor arrays
);

  // registered state and its next value
  unit_state_s state_reg;
  unit_state_s state_next;

  // edge and level views of the synchronised pins
  logic sclk_rise;   // sampling edge in both supported modes
  logic cs_rise;     // end of frame
  logic cs_low;      // frame in progress
  logic pr_rise;     // preset released
  logic pr_low;      // preset held
  logic wr_ok;       // write protect released

  // step function for the shift and step commands
  function automatic logic [WIPER_BITS-1:0] adjust
  (
    input logic [3:0]            code,
    input logic [WIPER_BITS-1:0] value
  );
    logic [WIPER_BITS-1:0] res;
    res = value;
    unique case (code)
      // right shift, settles at zero by itself
      CMD_HALVE_ONE, CMD_HALVE_ALL:
      begin
        res = value >> 1;
      end
      // step down, held at zero
      CMD_DEC_ONE, CMD_DEC_ALL:
      begin
        if (value != WIPER_ZERO)
        begin
          res = value - 6'h01;
        end
      end
      // left shift, clamped at the top code
      CMD_DOUBLE_ONE, CMD_DOUBLE_ALL:
      begin
        if (value[WIPER_BITS-1])
        begin
          res = WIPER_TOP;
        end
        else
        begin
          res = {value[WIPER_BITS-2:0], 1'b0};
        end
      end
      // step up, held at the top code
      CMD_INC_ONE, CMD_INC_ALL:
      begin
        if (value != WIPER_TOP)
        begin
          res = value + 6'h01;
        end
      end
      // other codes leave the value alone
      default:
      begin
        res = value;
      end
    endcase
    return res;
  endfunction : adjust

  // pin views taken only from second and third synchroniser stages
  assign sclk_rise = state_reg.sclk_s2 & ~state_reg.sclk_s3;
  assign cs_rise   = state_reg.cs_s2 & ~state_reg.cs_s3;
  assign cs_low    = ~state_reg.cs_s2;
  assign pr_rise   = state_reg.pr_s2 & ~state_reg.pr_s3;
  assign pr_low    = ~state_reg.pr_s2;
  assign wr_ok     = state_reg.wp_s2;

  // next-state logic of the whole unit
  always_comb
  begin
    frame_s            fr;
    logic              do_exec;
    logic [1:0]        sel;
    logic [3:0]        nv_idx;
    fr         = state_reg.shift;
    do_exec    = 1'b0;
    sel        = 2'b00;
    nv_idx     = 4'h0;
    state_next = state_reg;

    // two-stage synchronisers, third stage kept for edge finding
    state_next.sclk_s1 = sclk;
    state_next.sclk_s2 = state_reg.sclk_s1;
    state_next.sclk_s3 = state_reg.sclk_s2;
    state_next.cs_s1   = cs_n;
    state_next.cs_s2   = state_reg.cs_s1;
    state_next.cs_s3   = state_reg.cs_s2;
    state_next.sdi_s1  = sdi;
    state_next.sdi_s2  = state_reg.sdi_s1;
    state_next.wp_s1   = wp_n;
    state_next.wp_s2   = state_reg.wp_s1;
    state_next.pr_s1   = preset_strobe_n;
    state_next.pr_s2   = state_reg.pr_s1;
    state_next.pr_s3   = state_reg.pr_s2;

    unique case (state_reg.phase)
      // listening to the serial port
      PH_IDLE:
      begin
        // both modes sample on the rising clock edge and shift out after it
        if (cs_low && sclk_rise)
        begin
          // msb first; the old word leaves through the top bit
          state_next.shift    = {state_reg.shift[FRAME_BITS-2:0], state_reg.sdi_s2};
          state_next.bit_cnt  = state_reg.bit_cnt + 4'h1;
          state_next.any_bits = 1'b1;
        end
        // frame closes when select rises
        if (cs_rise)
        begin
          state_next.bit_cnt  = 4'h0;
          state_next.any_bits = 1'b0;
          if (!state_reg.any_bits)
          begin
            // bare select pulse repeats the previous command
            if (state_reg.last_valid)
            begin
              fr      = state_reg.last_frame;
              do_exec = 1'b1;
            end
          end
          else if (state_reg.bit_cnt[1:0] != 2'b00)
          begin
            // misaligned count: frame dropped, counter cleared
            do_exec = 1'b0;
          end
          else if (state_reg.bit_cnt == 4'h0)
          begin
            // whole sixteen-bit frames only; the last one received counts
            fr                    = state_reg.shift;
            do_exec               = 1'b1;
            state_next.last_frame = state_reg.shift;
            state_next.last_valid = 1'b1;
          end
        end
        sel    = fr.address_bits[1:0];
        nv_idx = fr.address_bits;
        if (do_exec)
        begin
          unique case (fr.command_bits)
            // nothing to do
            CMD_NOP:
            begin
              state_next.last_valid = state_reg.last_valid;
            end
            // reload one wiper, allowed even under write protect
            CMD_RESTORE_ONE:
            begin
              state_next.wiper[sel] = state_reg.nv[sel][WIPER_BITS-1:0];
            end
            // reload all wipers, allowed even under write protect
            CMD_RESTORE_ALL:
            begin
              for (int i = 0; i < WIPER_COUNT; i++)
              begin
                state_next.wiper[i] = state_reg.nv[i][WIPER_BITS-1:0];
              end
            end
            // save a wiper to its nonvolatile word
            CMD_STORE_WIPER:
            begin
              if (wr_ok)
              begin
                state_next.store_addr = {2'b00, sel};
                state_next.store_data = {2'b00, state_reg.wiper[sel]};
                state_next.timer      = '0;
                state_next.phase      = PH_STORE;
              end
            end
            // save the data byte to any nonvolatile word
            CMD_STORE_DATA:
            begin
              if (wr_ok)
              begin
                state_next.store_addr = nv_idx;
                state_next.store_data = fr.data_bits;
                state_next.timer      = '0;
                state_next.phase      = PH_STORE;
              end
            end
            // stored word goes out in the next frame
            CMD_READ_NV:
            begin
              state_next.shift = {fr.command_bits, fr.address_bits, state_reg.nv[nv_idx]};
            end
            // wiper goes out in the next frame
            CMD_READ_WIPER:
            begin
              state_next.shift = {fr.command_bits, fr.address_bits, 2'b00,
                                  state_reg.wiper[sel]};
            end
            // direct wiper load, six low data bits only; zero puts it at terminal b
            CMD_WRITE_WIPER:
            begin
              if (wr_ok)
              begin
                state_next.wiper[sel] = fr.data_bits[WIPER_BITS-1:0];
              end
            end
            // shift and step commands, one wiper or all of them
            default:
            begin
              if (wr_ok)
              begin
                for (int i = 0; i < WIPER_COUNT; i++)
                begin
                  if (fr.command_bits[0] || (sel == 2'(i)))
                  begin
                    state_next.wiper[i] = adjust(fr.command_bits, state_reg.wiper[i]);
                  end
                end
              end
            end
          endcase
        end
      end
      // store under way: shifter locked, select and clock ignored
      PH_STORE:
      begin
        state_next.bit_cnt  = 4'h0;
        state_next.any_bits = 1'b0;
        state_next.timer    = state_reg.timer + 22'h000001;
        if (state_reg.timer == TIMER_BITS'(STORE_WAIT - 1))
        begin
          // commit the word and start the ready pulse
          state_next.nv[state_reg.store_addr] = state_reg.store_data;
          state_next.timer  = '0;
          state_next.rdy_oe = 1'b1;
          state_next.phase  = PH_READY;
        end
      end
      // ready pin held low for a short pulse
      PH_READY:
      begin
        state_next.bit_cnt  = 4'h0;
        state_next.any_bits = 1'b0;
        state_next.timer    = state_reg.timer + 22'h000001;
        if (state_reg.timer == TIMER_BITS'(READY_PULSE_CYCLES - 1))
        begin
          state_next.rdy_oe = 1'b0;
          state_next.timer  = '0;
          state_next.phase  = PH_IDLE;
        end
      end
    endcase

    // preset pin overrides the serial port on the wipers
    if (pr_low)
    begin
      for (int i = 0; i < WIPER_COUNT; i++)
      begin
        state_next.wiper[i] = WIPER_MIDSCALE;
      end
    end
    else if (pr_rise)
    begin
      for (int i = 0; i < WIPER_COUNT; i++)
      begin
        state_next.wiper[i] = state_reg.nv[i][WIPER_BITS-1:0];
      end
    end

    // serial output pulls low only inside a frame and only for a zero bit
    state_next.sdo_oe = ~state_reg.cs_s2 & ~state_next.shift[FRAME_BITS-1];
  end

  // state register; power-on loads the factory store and wipers from it
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg            <= '0;
      state_reg.sclk_s1    <= 1'b0;
      state_reg.sclk_s2    <= 1'b0;
      state_reg.sclk_s3    <= 1'b0;
      state_reg.cs_s1      <= 1'b1;
      state_reg.cs_s2      <= 1'b1;
      state_reg.cs_s3      <= 1'b1;
      state_reg.wp_s1      <= 1'b1;
      state_reg.wp_s2      <= 1'b1;
      state_reg.pr_s1      <= 1'b1;
      state_reg.pr_s2      <= 1'b1;
      state_reg.pr_s3      <= 1'b1;
      state_reg.phase      <= PH_IDLE;
      state_reg.last_valid <= 1'b0;
      for (int i = 0; i < NV_WORDS; i++)
      begin
        if (i < WIPER_COUNT)
        begin
          state_reg.nv[i]    <= {2'b00, WIPER_MIDSCALE};
          state_reg.wiper[i] <= WIPER_MIDSCALE;
        end
        else
        begin
          state_reg.nv[i] <= NV_USER_RESET;
        end
      end
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // open-drain pins drive only a low level
  assign sdo_o      = 1'b0;
  assign sdo_oe     = state_reg.sdo_oe;
  assign rdy_o      = 1'b0;
  assign rdy_oe     = state_reg.rdy_oe;
  assign store_busy = (state_reg.phase == PH_STORE);
  assign wipers     = '{wiper_scratchpad: state_reg.wiper};

endmodule : quad_pot_serial_command_unit
